// *** core/tuner_cpu_core.sv ***
`timescale 1ns/10ps
`include "tuner_cpu_map.svh"

// Notes on behaviour
// - immediate add to memory; never, on carry, or on no carry skip
// - immediate plus carry add to memory, same three skip forms
// - register minus memory into register, skip never, on borrow, on no borrow
// - register minus memory minus borrow into register, same skip forms
// - memory minus immediate into memory, same skip forms
// - memory minus immediate minus borrow into memory, same skip forms
// - register versus memory compare, nothing stored; equal, unequal, not less, less
// - memory versus immediate compare, nothing stored; same four conditions
// - and and or of immediate into memory; xor of memory into register
// - load memory into register, store register, write immediate to memory
// - same-row moves via register-held column, and column to column copy
// - memory bit test with mask; skip if all one or all zero
// - branch and call load 10-bit address; call pushes; returns pop, one skips
// - timer flag test clears a set flag, skips when flag clear
// - page select codes drive the two page flags
// - enable pin tests skip on high or on low
// - remote signal test skips when the input is low
// - segment instruction latches indirect memory nibble and drives decoded pattern
// - port read into register, port write from register
// - port bit set, clear and all-one or all-zero tests with mask
// - comparator tests skip on above, or on at or below
// - general register is one of sixteen nibbles in page zero row zero
// - register plus memory into register, same three skip forms
module tuner_cpu_core #(
  parameter int INSTR_CYCLES = `INSTR_CYCLES,
  parameter int RAM_WORDS = 256
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // program memory
  output logic [9:0] ROM_ADDR,
  input wire logic [15:0] ROM_DATA,
  // pins and peripherals
  input wire logic CE,
  input wire logic REMOTE_SIGNAL_INPUT,
  input wire logic COMP_ABOVE,
  input wire logic TIMER_TICK,
  input wire logic [15:0] PORT_IN,
  output logic [15:0] PORT_OUT,
  output logic [6:0] SEG_OUT,
  output logic OSC_HALT
);

  // pattern group 0 then group 1, active low, g down to a
  localparam logic [6:0] SEG_TABLE [32] = '{
    7'h40, 7'h79, 7'h24, 7'h30, 7'h19, 7'h12, 7'h02, 7'h58,
    7'h00, 7'h10, 7'h7F, 7'h06, 7'h3F, 7'h77, 7'h1C, 7'h23,
    7'h00, 7'h7E, 7'h7D, 7'h7B, 7'h77, 7'h6F, 7'h5F, 7'h3F,
    7'h7F, 7'h7F, 7'h7F, 7'h7F, 7'h7F, 7'h7F, 7'h7F, 7'h7F};

  tuner_cpu_pkg::state_t s;
  tuner_cpu_pkg::state_t next_s;
  tuner_cpu_pkg::instr_t ir;
  logic [3:0] ram [RAM_WORDS];
  logic ram_we;
  logic [7:0] ram_wa;
  logic [3:0] ram_wd;
  logic [3:0] mem_m;
  logic [3:0] reg_r;
  logic [3:0] ind_m;
  logic [3:0] op_a;
  logic [3:0] op_b;
  logic [4:0] res;
  logic [4:0] diff;
  logic [3:0] port_sel;
  logic step;
  logic setup;
  logic access;

  assign ir = tuner_cpu_pkg::instr_t'(ROM_DATA);
  assign mem_m = ram[{s.page, ir.row, ir.col}];
  assign reg_r = ram[{4'h0, ir.low}];
  assign ind_m = ram[{s.page, ir.row, reg_r}];
  assign port_sel = s.port_out[ir.row * 4 +: 4];
  // register group takes register then memory, immediate group memory then immediate
  assign op_a = ir.op[5] ? reg_r : mem_m;
  assign op_b = ir.op[5] ? mem_m : ir.low;
  assign step = s.run && !s.halted && (s.div == 12'h000);
  assign setup = PSEL && !PENABLE;
  assign access = PSEL && PENABLE;

  always_comb begin
    logic with_cin;
    logic flag;
    logic [3:0] pin;
    with_cin = ir.op[1] & s.carry;
    flag = 1'b0;
    pin = PORT_IN[ir.row * 4 +: 4];
    res = ir.op[0] ? 5'({1'b0, op_a} - {1'b0, op_b} - {4'h0, with_cin}) :
                     5'({1'b0, op_a} + {1'b0, op_b} + {4'h0, with_cin});
    diff = 5'({1'b0, op_a} - {1'b0, op_b});
    next_s = s;
    ram_we = 1'b0;
    ram_wa = {s.page, ir.row, ir.col};
    ram_wd = 4'h0;
    next_s.div = (s.div == 12'h000) ? 12'(INSTR_CYCLES - 1) : 12'(s.div - 12'h001);
    if (step) begin
      next_s.pc = 10'(s.pc + 10'h001);
      if (s.skip) begin
        next_s.skip = 1'b0;
      end else begin
        case (ir.op)
          tuner_cpu_pkg::op_bits_set, tuner_cpu_pkg::op_bits_clear: begin
            flag = (ir.op == tuner_cpu_pkg::op_bits_set);
            if (ir.col == `SUB_PORT) begin
              next_s.port_out[ir.row * 4 +: 4] = flag ? (port_sel | ir.low) : (port_sel & ~ir.low);
            end else if (ir.col == `SUB_CARRY) begin
              next_s.carry = flag;
            end else if (ir.col == `SUB_PAGE_ONE && flag) begin
              next_s.page = 2'b01;
            end else if (ir.col == `SUB_PAGE_TWO && flag) begin
              next_s.page = 2'b10;
            end else if (ir.col == `SUB_PAGE_ZERO && !flag) begin
              next_s.page = 2'b00;
            end
          end
          tuner_cpu_pkg::op_return: begin
            next_s.pc = s.stack;
          end
          tuner_cpu_pkg::op_return_skip: begin
            next_s.pc = s.stack;
            next_s.skip = 1'b1;
          end
          tuner_cpu_pkg::op_branch: begin
            next_s.pc = ROM_DATA[9:0];
          end
          tuner_cpu_pkg::op_call: begin
            next_s.stack = 10'(s.pc + 10'h001);
            next_s.pc = ROM_DATA[9:0];
          end
          tuner_cpu_pkg::op_low_test, tuner_cpu_pkg::op_high_test: begin
            flag = ir.op[0];
            if (ir.col == `SUB_CARRY) begin
              next_s.skip = (CE == flag);
            end else if (ir.col == `SUB_PORT) begin
              next_s.skip = flag ? ((pin & ir.low) == ir.low) : ((pin & ir.low) == 4'h0);
            end
          end
          tuner_cpu_pkg::op_mem_zero_test: begin
            next_s.skip = ((mem_m & ir.low) == 4'h0);
          end
          tuner_cpu_pkg::op_mem_one_test: begin
            next_s.skip = ((mem_m & ir.low) == ir.low);
          end
          tuner_cpu_pkg::op_or_imm: begin
            ram_we = 1'b1;
            ram_wd = mem_m | ir.low;
          end
          tuner_cpu_pkg::op_and_imm: begin
            ram_we = 1'b1;
            ram_wd = mem_m & ir.low;
          end
          tuner_cpu_pkg::op_load_imm: begin
            ram_we = 1'b1;
            ram_wd = ir.low;
          end
          tuner_cpu_pkg::op_segment: begin
            next_s.seg_latch = {reg_r[3], ind_m};
            next_s.seg_pattern = SEG_TABLE[{reg_r[3], ind_m}];
          end
          tuner_cpu_pkg::op_port_write: begin
            next_s.port_out[ir.row * 4 +: 4] = reg_r;
          end
          tuner_cpu_pkg::op_halt: begin
            next_s.halted = !CE;
          end
          tuner_cpu_pkg::op_row_copy: begin
            ram_we = 1'b1;
            ram_wd = ram[{s.page, ir.row, ir.low}];
          end
          tuner_cpu_pkg::op_xor: begin
            ram_we = 1'b1;
            ram_wa = {4'h0, ir.low};
            ram_wd = reg_r ^ mem_m;
          end
          tuner_cpu_pkg::op_load, tuner_cpu_pkg::op_port_read: begin
            ram_we = 1'b1;
            ram_wa = {4'h0, ir.low};
            ram_wd = ir.op[4] ? pin : mem_m;
          end
          tuner_cpu_pkg::op_signal_test: begin
            if (ir.col == `SUB_PORT && ir.row == `ROW_COMP_ABOVE) begin
              next_s.skip = COMP_ABOVE;
            end else if (ir.col == `SUB_PORT && ir.row == `ROW_COMP_BELOW) begin
              next_s.skip = !COMP_ABOVE;
            end else begin
              next_s.skip = !REMOTE_SIGNAL_INPUT;
            end
          end
          tuner_cpu_pkg::op_timer_test: begin
            next_s.timer = 1'b0;
            next_s.skip = !s.timer;
          end
          tuner_cpu_pkg::op_store: begin
            ram_we = 1'b1;
            ram_wd = reg_r;
          end
          tuner_cpu_pkg::op_src_move: begin
            ram_we = 1'b1;
            ram_wd = ind_m;
          end
          tuner_cpu_pkg::op_dest_move: begin
            ram_we = 1'b1;
            ram_wa = {s.page, ir.row, reg_r};
            ram_wd = mem_m;
          end
          default: begin
            if (ir.op[4] && ir.op[3:2] != 2'b00) begin
              // add and subtract, immediate group and register group
              ram_we = 1'b1;
              ram_wa = ir.op[5] ? {4'h0, ir.low} : {s.page, ir.row, ir.col};
              ram_wd = res[3:0];
              next_s.carry = res[4];
              if (ir.op[3]) begin
                next_s.skip = ir.op[2] ? res[4] : !res[4];
              end
            end else if (!ir.op[4] && ir.op[3:2] == 2'b11) begin
              case (ir.op[1:0])
                2'b10: next_s.skip = (diff[3:0] == 4'h0);
                2'b11: next_s.skip = (diff[3:0] != 4'h0);
                2'b01: next_s.skip = !diff[4];
                default: next_s.skip = diff[4];
              endcase
            end
          end
        endcase
      end
    end
    if (s.halted && CE) begin
      next_s.halted = 1'b0;
    end
    if (TIMER_TICK) begin
      next_s.timer = 1'b1;
    end
    // apb read data captured in the setup phase
    if (setup) begin
      next_s.pslverr = 1'b0;
      next_s.prdata = 32'h0000_0000;
      if (PADDR == `OFS_CONTROL) begin
        next_s.prdata[`CTRL_RUN_BIT] = s.run;
        next_s.prdata[`CTRL_TIMER_BIT] = s.timer;
      end else if (PADDR == `OFS_STATUS) begin
        next_s.prdata[`STAT_PC_LSB +: 10] = s.pc;
        next_s.prdata[`STAT_CARRY_BIT] = s.carry;
        next_s.prdata[`STAT_PAGE_LSB +: 2] = s.page;
        next_s.prdata[`STAT_SKIP_BIT] = s.skip;
        next_s.prdata[`STAT_TIMER_BIT] = s.timer;
        next_s.prdata[`STAT_HALT_BIT] = s.halted;
      end else if (PADDR == `OFS_SEGMENT) begin
        next_s.prdata[11:0] = {s.seg_pattern, s.seg_latch};
      end else if (PADDR == `OFS_PORTS) begin
        next_s.prdata[15:0] = s.port_out;
      end else begin
        next_s.pslverr = 1'b1;
      end
    end
    if (access && PWRITE && PADDR == `OFS_CONTROL) begin
      next_s.run = PWDATA[`CTRL_RUN_BIT];
      if (PWDATA[`CTRL_TIMER_BIT]) begin
        next_s.timer = 1'b1;
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      s <= '0;
      s.pc <= `PC_RESET;
      s.run <= 1'(`CTRL_RESET >> `CTRL_RUN_BIT);
      s.seg_pattern <= `SEG_PATTERN_RESET;
      s.port_out <= `PORT_OUT_RESET;
    end else begin
      s <= next_s;
    end
  end

  always_ff @(posedge MCLK) begin
    if (ram_we && !RST) begin
      ram[ram_wa] <= ram_wd;
    end
  end

  assign PRDATA = s.prdata;
  assign PREADY = access;
  assign PSLVERR = access && s.pslverr;
  assign ROM_ADDR = s.pc;
  assign PORT_OUT = s.port_out;
  assign SEG_OUT = s.seg_pattern;
  assign OSC_HALT = s.halted;

endmodule : tuner_cpu_core

// *** core/tuner_cpu_map.svh ***
`ifndef TUNER_CPU_MAP_SVH
`define TUNER_CPU_MAP_SVH

// register byte offsets
`define OFS_CONTROL 12'h000
`define OFS_STATUS 12'h004
`define OFS_SEGMENT 12'h008
`define OFS_PORTS 12'h00C

// control register fields
`define CTRL_RUN_BIT 0
`define CTRL_TIMER_BIT 1
`define CTRL_RESET 32'h0000_0001

// status register field positions
`define STAT_PC_LSB 0
`define STAT_CARRY_BIT 10
`define STAT_PAGE_LSB 11
`define STAT_SKIP_BIT 13
`define STAT_TIMER_BIT 14
`define STAT_HALT_BIT 15

// reset values
`define PC_RESET 10'h000
`define SEG_PATTERN_RESET 7'h7F
`define PORT_OUT_RESET 16'h0000

// sub-codes in the column field
`define SUB_PORT 4'h0
`define SUB_CARRY 4'h2
`define SUB_PAGE_ONE 4'h4
`define SUB_PAGE_TWO 4'h8
`define SUB_PAGE_ZERO 4'hC

// analog test selector in the row field
`define ROW_COMP_ABOVE 2'b00
`define ROW_COMP_BELOW 2'b10

// instruction cycle time and its count at 25 MHz
`define INSTR_TIME_NS 33300
`define MCLK_PERIOD_NS 40
`define INSTR_CYCLES (`INSTR_TIME_NS / `MCLK_PERIOD_NS)

`endif

// *** core/tuner_cpu_pkg.sv ***
package tuner_cpu_pkg;

  typedef enum logic [5:0] {
    op_nop           = 6'b000000,
    op_bits_set      = 6'b000001,
    op_bits_clear    = 6'b000011,
    op_return        = 6'b000100,
    op_return_skip   = 6'b000101,
    op_branch        = 6'b000110,
    op_call          = 6'b000111,
    op_low_test      = 6'b001000,
    op_high_test     = 6'b001001,
    op_mem_zero_test = 6'b001010,
    op_mem_one_test  = 6'b001011,
    op_or_imm        = 6'b010001,
    op_load_imm      = 6'b010010,
    op_and_imm       = 6'b010011,
    op_segment       = 6'b100001,
    op_port_write    = 6'b100010,
    op_halt          = 6'b100011,
    op_row_copy      = 6'b100100,
    op_xor           = 6'b100101,
    op_load          = 6'b100110,
    op_signal_test   = 6'b101000,
    op_timer_test    = 6'b101001,
    op_store         = 6'b110000,
    op_src_move      = 6'b110001,
    op_port_read     = 6'b110010,
    op_dest_move     = 6'b110011
  } opcode_t;

  typedef struct packed {
    logic [5:0] op;
    logic [1:0] row;
    logic [3:0] col;
    logic [3:0] low;
  } instr_t;

  typedef struct packed {
    logic [9:0] pc;
    logic [9:0] stack;
    logic carry;
    logic [1:0] page;
    logic skip;
    logic timer;
    logic halted;
    logic run;
    logic [4:0] seg_latch;
    logic [6:0] seg_pattern;
    logic [15:0] port_out;
    logic [31:0] prdata;
    logic pslverr;
    logic [11:0] div;
  } state_t;

endpackage : tuner_cpu_pkg

// *** testbench/tuner_cpu_core_properties.sv ***
`timescale 1ns/10ps
module tuner_cpu_core_checker #(
  parameter int INSTR_CYCLES = 832,
  parameter int RAM_WORDS = 256
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // apb
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // core
  input wire logic [9:0] ROM_ADDR,
  input wire logic [15:0] ROM_DATA,
  input wire logic CE,
  input wire logic [15:0] PORT_OUT,
  input wire logic [6:0] SEG_OUT,
  input wire logic OSC_HALT
);
  logic [15:0] last_word;
  logic [9:0] last_pc;

  always_ff @(posedge MCLK) begin
    last_word <= ROM_DATA;
    last_pc <= ROM_ADDR;
  end

  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);

  property p_rdy_on; PSEL && PENABLE |-> PREADY; endproperty
  property p_rdy_off; !PSEL |-> !PREADY; endproperty
  property p_err_bad; PSEL && PENABLE && PADDR[11:4] != 8'h00 |-> PSLVERR; endproperty
  property p_err_good; PSEL && PENABLE && PADDR[11:4] == 8'h00 && PADDR[1:0] == 2'h0 |-> !PSLVERR; endproperty
  property p_reset_out; $fell(RST) |-> SEG_OUT == 7'h7F && PORT_OUT == 16'h0000 && ROM_ADDR == 10'h000; endproperty
  property p_step_gap; $changed(ROM_ADDR) && !$past(RST) |=> $stable(ROM_ADDR); endproperty
  property p_port_gap; $changed(PORT_OUT) && !$past(RST) |-> ##1 $stable(PORT_OUT); endproperty
  property p_branch;
    $changed(ROM_ADDR) && !$past(RST) && last_word[15:10] == 6'h06
      |-> ROM_ADDR == last_word[9:0] || ROM_ADDR == last_pc + 10'h001;
  endproperty
  property p_halt_ce; $past(CE) |-> !OSC_HALT; endproperty

  a_rdy_on: assert property (p_rdy_on) else $error("pready low in access");
  a_rdy_off: assert property (p_rdy_off) else $error("pready high while idle");
  a_err_bad: assert property (p_err_bad) else $error("no error on unmapped address");
  a_err_good: assert property (p_err_good) else $error("error on mapped address");
  a_reset_out: assert property (p_reset_out) else $error("outputs not at reset values");
  a_step_gap: assert property (p_step_gap) else $error("pc moved twice in a row");
  a_port_gap: assert property (p_port_gap) else $error("port output moved off step");
  a_branch: assert property (p_branch) else $error("branch target wrong");
  a_halt_ce: assert property (p_halt_ce) else $error("halt with enable high");

  c_err: cover property (PSLVERR);
  c_skip_mark: cover property ($rose(PORT_OUT[12]));
  c_write: cover property (PSEL && PENABLE && PWRITE);
endmodule : tuner_cpu_core_checker

bind tuner_cpu_core tuner_cpu_core_checker #(.INSTR_CYCLES(INSTR_CYCLES), .RAM_WORDS(RAM_WORDS)) i_checker (
  .MCLK(MCLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .ROM_ADDR(ROM_ADDR), .ROM_DATA(ROM_DATA), .CE(CE),
  .PORT_OUT(PORT_OUT), .SEG_OUT(SEG_OUT), .OSC_HALT(OSC_HALT)
);

// *** testbench/prog_rom_model.sv ***
`timescale 1ns/10ps
module prog_rom_model (
  // fetch
  input wire logic [9:0] addr,
  output logic [15:0] data
);
  logic [15:0] words [1024];

  initial for (int i = 0; i < 1024; i++) words[i] = 16'h0000;
  // asynchronous read over the whole 10-bit space
  assign data = words[addr];
endmodule : prog_rom_model

// *** testbench/testbench.sv ***
`timescale 1ns/10ps
module testbench;
  localparam int STEP = 2;
  logic mclk, rst, psel, penable, pwrite, pready, pslverr, ce, remote, above, tick, osc_halt, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [9:0] rom_addr;
  logic [15:0] rom_data, port_in, port_out;
  logic [6:0] seg_out;
  int fails, checks_done;
  // carry in, opcode, memory, register or immediate, memory out, register out, {skip, carry}
  logic [31:0] rows [44] = '{
    32'h01498181, 32'h01C98183, 32'h01898181,
    32'h11678081, 32'h11E23630, 32'h11A23632,
    32'h035535E1, 32'h03D535E3, 32'h039535E1,
    32'h13749440, 32'h13F444F3, 32'h03B44402,
    32'h01553230, 32'h01D35E53, 32'h01935E51,
    32'h11753130, 32'h11F33F33, 32'h01B33032,
    32'h03489811, 32'h03C89813, 32'h03821232,
    32'h12E66663, 32'h02F66660, 32'h02D53530, 32'h12C53533,
    32'h00E66662, 32'h00F56562, 32'h00D56560, 32'h00C56562,
    32'h013CA8A0, 32'h011CAEA0, 32'h025CAC60,
    32'h02653550, 32'h03053330, 32'h01253330,
    32'h00B73732, 32'h00B43430, 32'h00A43432,
    32'h02953532, 32'h02853532,
    32'h0095C5C2, 32'h00853532, 32'h00854540,
    32'h032535C0
  };

  tuner_cpu_core #(.INSTR_CYCLES(STEP)) i_dut (
    .MCLK(mclk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .ROM_ADDR(rom_addr),
    .ROM_DATA(rom_data), .CE(ce), .REMOTE_SIGNAL_INPUT(remote), .COMP_ABOVE(above), .TIMER_TICK(tick),
    .PORT_IN(port_in), .PORT_OUT(port_out), .SEG_OUT(seg_out), .OSC_HALT(osc_halt)
  );

  prog_rom_model i_rom (.addr(rom_addr), .data(rom_data));

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    q = prdata;
    e = pslverr;
    if (n >= 20) begin
      fails++;
      $display("MISMATCH t=%0t apb wait ran out", $time);
      print_verdict();
    end
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  // load a short program, reset, run it out and read back ports and status
  task automatic run_row(input logic [31:0] r, input logic tk, input logic rm);
    logic [3:0] b;
    b = r[15:12];
    @(posedge mclk);
    rst <= 1'h1;
    remote <= rm;
    i_rom.words[0] = {r[28] ? 6'h01 : 6'h03, 6'h02, 4'h0};
    i_rom.words[1] = {6'h12, 6'h10, r[19:16]};
    i_rom.words[2] = {6'h12, 2'h0, b, b};
    i_rom.words[3] = {r[25:20], 6'h10, b};
    i_rom.words[4] = {6'h01, 6'h30, 4'h1};
    i_rom.words[5] = {6'h26, 6'h10, 4'hF};
    i_rom.words[6] = {6'h22, 6'h10, 4'hF};
    i_rom.words[7] = {6'h22, 2'h0, 4'h0, b};
    i_rom.words[8] = {6'h06, 10'h3FF};
    i_rom.words[1023] = {6'h06, 10'h3FF};
    @(posedge mclk);
    rst <= 1'h0;
    tick <= tk;
    @(posedge mclk);
    tick <= 1'h0;
    repeat (10 * STEP + 2) @(posedge mclk);
    chk({16'h0, port_out}, {16'h0, 3'h0, ~r[1], 4'h0, r[11:8], r[7:4]}, "ports");
    apb(1'h0, 12'h004, 32'h0);
    chk({16'h0, q[15:0]}, {21'h0, r[0], 10'h3FF}, "status");
  endtask : run_row

  initial begin
    mclk = 1'h0;
    forever #20 mclk = ~mclk;
  end

  initial begin
    rst = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    ce = 1'h1;
    remote = 1'h0;
    above = 1'h0;
    tick = 1'h0;
    port_in = 16'h00C0;
    fails = 0;
    checks_done = 0;
    repeat (5) @(posedge mclk);
    chk({14'h0, seg_out, osc_halt, rom_addr}, {14'h0, 7'h7F, 1'h0, 10'h000}, "reset pins");
    chk({16'h0, port_out}, 32'h0, "reset ports");
    rst <= 1'h0;
    apb(1'h0, 12'h000, 32'h0);
    chk(q, 32'h00000001, "control reset");
    apb(1'h1, 12'h000, 32'h0);
    apb(1'h0, 12'h000, 32'h0);
    chk(q, 32'h0, "control cleared");
    apb(1'h0, 12'h010, 32'h0);
    chk({e, q[30:0]}, 32'h80000000, "unmapped read");
    $display("register test done");
    for (int i = 0; i < 44; i++) begin
      run_row(rows[i], 1'h0, 1'h0);
      $display("row %0d done", i);
    end
    run_row(32'h02953530, 1'h1, 1'h1);
    $display("timer tick test done");
    run_row(32'h02853530, 1'h0, 1'h1);
    $display("remote high test done");
    // call, return with skip, segment, page, comparator, enable pin and halt
    @(posedge mclk);
    rst <= 1'h1;
    ce <= 1'h0;
    above <= 1'h1;
    i_rom.words[0] = {6'h07, 10'h010};
    i_rom.words[1] = {6'h01, 6'h30, 4'h1};
    i_rom.words[2] = {6'h01, 6'h04, 4'h0};
    i_rom.words[3] = {6'h28, 6'h00, 4'h0};
    i_rom.words[4] = {6'h01, 6'h30, 4'h2};
    i_rom.words[5] = {6'h28, 6'h20, 4'h0};
    i_rom.words[6] = {6'h01, 6'h30, 4'h4};
    i_rom.words[7] = {6'h08, 6'h02, 4'h0};
    i_rom.words[8] = {6'h01, 6'h30, 4'h8};
    i_rom.words[9] = {6'h23, 6'h3E, 4'hE};
    i_rom.words[10] = {6'h06, 10'h3FF};
    i_rom.words[16] = {6'h12, 2'h0, 4'h2, 4'h3};
    i_rom.words[17] = {6'h12, 2'h1, 4'h3, 4'h3};
    i_rom.words[18] = {6'h21, 2'h1, 4'h0, 4'h2};
    i_rom.words[19] = {6'h05, 10'h000};
    @(posedge mclk);
    rst <= 1'h0;
    repeat (40) @(posedge mclk);
    chk({21'h0, osc_halt, rom_addr}, {21'h0, 1'h1, 10'h00A}, "halted");
    chk({16'h0, port_out}, 32'h00004000, "skips");
    chk({25'h0, seg_out}, {25'h0, 7'h30}, "segment");
    ce <= 1'h1;
    repeat (10) @(posedge mclk);
    apb(1'h0, 12'h004, 32'h0);
    chk({16'h0, q[15:0]}, 32'h00000BFF, "page and pc");
    $display("call and pin test done");
    print_verdict();
  end
endmodule : testbench
